// ### rtl/mrs_pkg.sv
// =====================================================================
// Shared constants and carriers for the microstep reference sequencer
package mrs_pkg;

  // =====================================================================
  // Timing
  localparam int MRS_CLK_HZ = 125_000_000;
  localparam int MRS_PWM_FREQ_HZ = 78_000;
  // Carrier period in clocks, rounded down
  localparam logic [10:0] MRS_PWM_CYCLES = 11'(MRS_CLK_HZ / MRS_PWM_FREQ_HZ);
  localparam logic [7:0] MRS_DUTY_FULL = 8'h0ff;

  // =====================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] MRS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MRS_OFS_RATE = 8'h04;
  localparam logic [7:0] MRS_OFS_STEPS = 8'h08;
  localparam logic [7:0] MRS_OFS_STATUS = 8'h0c;
  localparam logic [7:0] MRS_OFS_TABLE = 8'h40;

  // Control fields
  localparam int MRS_CTRL_RUN = 0;
  localparam int MRS_CTRL_DIR = 1;
  localparam int MRS_CTRL_ENABLE = 2;
  localparam int MRS_CTRL_DRESET = 3;
  localparam int MRS_CTRL_AUTO = 4;
  localparam int MRS_CTRL_DECAY = 5;

  // Values after reset
  localparam logic [5:0] MRS_CTRL_RESET = 6'h10;
  localparam logic [15:0] MRS_RATE_RESET = 16'h0040;
  localparam logic [3:0] MRS_STEPS_RESET = 4'h8;
  localparam logic [3:0] MRS_TABLE_LAST = 4'hf;
  // Duty codes for positions 0..8, one byte each, position 0 lowest
  localparam logic [8:0][7:0] MRS_DUTY_RESET =
    {8'hff, 8'hfa, 8'heb, 8'hd4, 8'hb4, 8'h8e, 8'h61, 8'h32, 8'h00};

  // Driver configuration level for full step two-phase-on
  localparam logic MRS_HALF_FULL_FULL = 1'b0;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mrs_wb_req_type;

  typedef struct packed {
    logic step_clock;
    logic direction_select;
    logic decay_select;
    logic half_full;
    logic enable;
    logic reset;
  } mrs_drv_type;

endpackage

// ### rtl/mrs_sequencer.sv
`timescale 1ns/100ps
// Operation
// R1: Each reference is a 78 kHz PWM output whose duty encodes its level.
// R2: Positions zero, one, two use duty codes 0, 50 and 97.
// R3: Positions three, four, five use duty codes 142, 180 and 212.
// R4: Positions six, seven, eight use 235, 250, 255; 255 is full scale.
// R5: Each microstep advances 11.25 electrical degrees, nine levels per step.
// R6: Both references stay 90 degrees apart; one rises while other falls.
// R7: References are never negative; driver supplies polarity per quadrant.
// R8: Driver is configured for full-step two-phase-on operation.
// R9: Driver cycles coil polarities through only four combinations.
// R10: Driver steps on each step clock transition; clock made periodically.
// R11: At reference level driver forces current down for constant off time.
// R12: Decay input high gives slow recirculation, low gives fast decay.
// R13: Slow decay at peaks, fast at zeros, per quadrant, inverted on reversal.
// R14: Levels per step are software-changeable.
// R15: Drive direction, decay, half/full, enable and reset besides step clock.
// R16: 8-bit duty, 255 constant high, new code taken at next period start.
module mrs_sequencer
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire mrs_pkg::mrs_wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output mrs_pkg::mrs_drv_type drv,
  output logic pwm_a,
  output logic pwm_b
);
  import mrs_pkg::*;

  // =====================================================================
  // Helpers
  // Merge written byte lanes into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
    input logic [31:0] new_w, input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[8*i +: 8] = new_w[8*i +: 8];
    end
    return res;
  endfunction

  // Compare threshold for a duty code; 255 gives the full period
  function automatic logic [10:0] duty_thr(input logic [7:0] duty);
    logic [18:0] prod;
    prod = 19'(duty) * 19'(MRS_PWM_CYCLES);
    return 11'(prod / 19'(MRS_DUTY_FULL));
  endfunction

  // =====================================================================
  // Register state
  logic [5:0] ctrl, next_ctrl;
  logic [15:0] rate, next_rate;
  logic [3:0] steps, next_steps;
  logic [7:0] table_mem [0:15];
  logic [7:0] next_table [0:15];
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic wr_hit;
  logic [3:0] steps_eff;

  // Sequencer and carrier state
  logic [10:0] pwm_cnt, next_pwm_cnt;
  logic [10:0] thr_a, next_thr_a, thr_b, next_thr_b;
  logic [15:0] rate_cnt, next_rate_cnt;
  logic [3:0] idx, next_idx;
  logic [1:0] quad, next_quad;
  logic step_clk, next_step_clk;
  logic decay, next_decay;
  logic out_a, next_out_a, out_b, next_out_b;
  logic pwm_wrap, micro_tick, step_wrap;
  logic [3:0] addr_a, addr_b;
  logic [7:0] ref_a, ref_b;
  logic decay_calc;

  assign steps_eff = (steps == 4'h0) ? 4'h1 : steps;
  // Write lands at the edge where the master sees ack
  assign wr_hit = wb_req.cyc && wb_req.stb && wb_req.we && ack;

  // =====================================================================
  // Wishbone slave: one wait state, unmapped reads return zero
  always_comb
  begin
    next_ctrl = ctrl;
    next_rate = rate;
    next_steps = steps;
    for (int i = 0; i < 16; i++)
      next_table[i] = table_mem[i];
    next_ack = wb_req.cyc && wb_req.stb && !ack;
    next_rdata = 32'h0000_0000;
    if (wr_hit)
    begin
      unique case (wb_req.adr)
        MRS_OFS_CTRL:
          next_ctrl = 6'(lane_merge(32'(ctrl), wb_req.dat, wb_req.sel));
        MRS_OFS_RATE:
          next_rate = 16'(lane_merge(32'(rate), wb_req.dat, wb_req.sel));
        MRS_OFS_STEPS:
          next_steps = 4'(lane_merge(32'(steps), wb_req.dat, wb_req.sel));
        default:
          // Duty table entries, one per word [R14]
          if (wb_req.adr[7:6] == MRS_OFS_TABLE[7:6] && wb_req.sel[0])
            next_table[wb_req.adr[5:2]] = wb_req.dat[7:0];
      endcase
    end
    if (next_ack)
    begin
      unique case (wb_req.adr)
        MRS_OFS_CTRL: next_rdata = 32'(ctrl);
        MRS_OFS_RATE: next_rdata = 32'(rate);
        MRS_OFS_STEPS: next_rdata = 32'(steps);
        MRS_OFS_STATUS:
          next_rdata = {ref_b, ref_a, 9'h000, step_clk, quad, idx};
        default:
          if (wb_req.adr[7:6] == MRS_OFS_TABLE[7:6])
            next_rdata = 32'(table_mem[wb_req.adr[5:2]]);
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= MRS_CTRL_RESET;
      rate <= MRS_RATE_RESET;
      steps <= MRS_STEPS_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      for (int i = 0; i < 9; i++)
        table_mem[i] <= MRS_DUTY_RESET[i]; // [R2][R3][R4]
      // Spare entries sit at full scale
      for (int i = 9; i < 16; i++)
        table_mem[i] <= MRS_DUTY_FULL;
    end
    else
    begin
      ctrl <= next_ctrl;
      rate <= next_rate;
      steps <= next_steps;
      ack <= next_ack;
      rdata <= next_rdata;
      for (int i = 0; i < 16; i++)
        table_mem[i] <= next_table[i];
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // =====================================================================
  // Reference selection: one channel rises, the other falls
  assign addr_b = quad[0] ? steps_eff - idx : idx; // [R6]
  assign addr_a = quad[0] ? idx : steps_eff - idx; // [R6]
  // Unsigned codes only; polarity left to the driver's decoder
  assign ref_a = table_mem[addr_a]; // [R7]
  assign ref_b = table_mem[addr_b]; // [R7]
  // Slow decay in the half nearer a peak, flipped by quadrant and direction
  assign decay_calc = ({idx, 1'b0} < 5'(steps_eff)) ^ quad[0]
                      ^ ctrl[MRS_CTRL_DIR]; // [R13]

  assign pwm_wrap = (pwm_cnt == MRS_PWM_CYCLES - 11'h001);
  assign micro_tick = pwm_wrap && ctrl[MRS_CTRL_RUN]
                      && (rate_cnt >= rate);
  assign step_wrap = (idx + 4'h1 >= steps_eff);

  // Carrier, microstep and step clock next state
  always_comb
  begin
    next_pwm_cnt = pwm_wrap ? 11'h000 : pwm_cnt + 11'h001; // [R1]
    next_thr_a = thr_a;
    next_thr_b = thr_b;
    next_rate_cnt = rate_cnt;
    next_idx = idx;
    next_quad = quad;
    next_step_clk = step_clk;
    if (pwm_wrap)
    begin
      // New codes only at a period boundary [R16]
      next_thr_a = duty_thr(ref_a);
      next_thr_b = duty_thr(ref_b);
      next_rate_cnt = micro_tick ? 16'h0000 : rate_cnt + 16'h0001;
    end
    if (micro_tick)
    begin
      if (step_wrap)
      begin
        next_idx = 4'h0;
        // Driver advances once per transition [R10]
        next_step_clk = !step_clk;
        next_quad = ctrl[MRS_CTRL_DIR] ? quad - 2'h1 : quad + 2'h1;
      end
      else
        next_idx = idx + 4'h1; // [R5]
    end
    // Threshold equal to period gives constant high [R16]
    next_out_a = (next_pwm_cnt < next_thr_a);
    next_out_b = (next_pwm_cnt < next_thr_b);
    next_decay = ctrl[MRS_CTRL_AUTO] ? decay_calc : ctrl[MRS_CTRL_DECAY];
  end

  // Carrier and sequencer flops
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_cnt <= 11'h000;
      thr_a <= 11'h000;
      thr_b <= 11'h000;
      rate_cnt <= 16'h0000;
      idx <= 4'h0;
      quad <= 2'h0;
      step_clk <= 1'b0;
      decay <= 1'b0;
      out_a <= 1'b0;
      out_b <= 1'b0;
    end
    else
    begin
      pwm_cnt <= next_pwm_cnt;
      thr_a <= next_thr_a;
      thr_b <= next_thr_b;
      rate_cnt <= next_rate_cnt;
      idx <= next_idx;
      quad <= next_quad;
      step_clk <= next_step_clk;
      decay <= next_decay;
      out_a <= next_out_a;
      out_b <= next_out_b;
    end
  end

  // =====================================================================
  // Driver pins, all from flops except half_full, which is a constant
  assign pwm_a = out_a; // [R1]
  assign pwm_b = out_b; // [R1]
  assign drv.step_clock = step_clk; // [R10][R15]
  assign drv.direction_select = ctrl[MRS_CTRL_DIR]; // [R15]
  assign drv.decay_select = decay; // [R13][R15]
  assign drv.half_full = MRS_HALF_FULL_FULL; // [R8][R15]
  assign drv.enable = ctrl[MRS_CTRL_ENABLE]; // [R15]
  assign drv.reset = ctrl[MRS_CTRL_DRESET]; // [R15]

  // =====================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_pwm_period_wrap: assert property ( // [R1]
    pwm_cnt == MRS_PWM_CYCLES - 11'h001 |=> pwm_cnt == 11'h000 ##1
    pwm_cnt == 11'h001)
    else $error("carrier period length wrong");

  a_full_scale_high: assert property ( // [R4][R16]
    thr_a == MRS_PWM_CYCLES && $stable(thr_a) |-> pwm_a)
    else $error("full scale duty not constant high");

  a_zero_duty_low: assert property ( // [R2]
    thr_b == 11'h000 && $stable(thr_b) |-> !pwm_b)
    else $error("zero duty output not low");

  a_duty_at_boundary: assert property ( // [R16]
    !pwm_wrap |=> $stable(thr_a) && $stable(thr_b))
    else $error("duty changed inside a period");

  a_quadrature_sum: assert property ( // [R6]
    5'(addr_a) + 5'(addr_b) == 5'(steps_eff))
    else $error("references not complementary");

  a_step_on_wrap: assert property ( // [R10]
    micro_tick && step_wrap |=> step_clk != $past(step_clk) && idx == 4'h0)
    else $error("step clock did not toggle at step end");

  a_step_hold: assert property ( // [R10]
    !micro_tick |=> $stable(step_clk) && $stable(quad))
    else $error("step clock moved without a tick");

  a_index_range: assert property ( // [R5][R14]
    idx < steps_eff)
    else $error("microstep index beyond levels per step");

  a_full_step_mode: assert property ( // [R8]
    drv.half_full == MRS_HALF_FULL_FULL)
    else $error("driver not in full step");

  a_decay_auto: assert property ( // [R13]
    ctrl[MRS_CTRL_AUTO] |=> drv.decay_select == $past(decay_calc))
    else $error("automatic decay level wrong");

  a_ref_nonneg_src: assert property ( // [R7]
    pwm_wrap |=> thr_a == duty_thr($past(ref_a)))
    else $error("reference not taken from duty table");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_step_toggle: cover property (micro_tick && step_wrap);
  c_reverse: cover property ($changed(drv.direction_select));
  c_table_write: cover property (wr_hit && wb_req.adr[6]);
  c_full_turn: cover property (quad == 2'h3 ##1 quad == 2'h0);

endmodule

// ### dv/mrs_driver_model.sv
`timescale 1ns/100ps
// ==========================================================
// Bridge driver stand-in: step decoding and decay choice
module mrs_driver_model
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire mrs_pkg::mrs_drv_type drv,
  output logic [7:0] position,
  output logic [1:0] coil_polarity,
  output logic slow_decay
);
  import mrs_pkg::*;
  logic last_step = 1'b0;
  logic [7:0] pos = 8'h00;

  // One full step per step clock transition, while enabled
  always @(posedge mclk)
  begin
    last_step <= drv.step_clock;
    if (drv.enable === 1'b1 && drv.step_clock !== last_step)
      pos <= drv.direction_select ? pos - 8'h01 : pos + 8'h01;
  end
  assign position = pos;

  // Only four polarity pairs, taken from the low position bits
  assign coil_polarity = {position[1], position[1] ^ position[0]};
  // Off-time path: high selects slow recirculation
  assign slow_decay = drv.decay_select;
endmodule

// ### dv/mrs_sequencer_test.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the microstep reference sequencer
module mrs_sequencer_test;
  import mrs_pkg::*;
  localparam int per = 1602;
  localparam logic [7:0] duty [9] = '{8'h00, 8'h32, 8'h61, 8'h8e,
    8'hb4, 8'hd4, 8'heb, 8'hfa, 8'hff};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  mrs_wb_req_type wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  mrs_drv_type drv;
  logic pwm_a;
  logic pwm_b;
  logic [7:0] position;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Clock, 8 ns period
  always #4 mclk = ~mclk;

  mrs_sequencer uut (.mclk(mclk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drv(drv),
    .pwm_a(pwm_a), .pwm_b(pwm_b));
  mrs_driver_model driver (.mclk(mclk), .drv(drv), .position(position),
    .coil_polarity(), .slow_decay());

  // Verdict and end of run
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    check("ack", 1'b1, wb_ack_o);
    wb_req <= '0;
    @(posedge mclk);
  endtask

  // High cycles of one reference over one carrier period
  task automatic high_count(input logic b, output int h);
    h = 0;
    repeat (per)
    begin
      @(posedge mclk);
      if ((b ? pwm_b : pwm_a) === 1'b1)
        h++;
    end
  endtask

  task automatic t_reset();
    bus(1'b0, 8'h00, '0);
    check("ctrl", 32'h0000_0010, rd);
    bus(1'b0, 8'h08, '0);
    check("steps", 32'h0000_0008, rd);
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b0, 8'h40 + 8'(4 * i), '0);
      check("table", (i < 9) ? duty[i] : 8'hff, rd);
    end
    bus(1'b0, 8'h20, '0);
    check("unmapped", '0, rd);
    check("half_full", 1'b0, drv.half_full);
    $display("test reset done");
  endtask

  task automatic t_pwm();
    int h;
    // First codes are only latched at the first carrier wrap
    repeat (2 * per) @(posedge mclk);
    high_count(1'b0, h);
    check("pwm a full", per, h);
    high_count(1'b1, h);
    check("pwm b zero", 0, h);
    bus(1'b1, 8'h40, 32'h0000_0080);
    repeat (3 * per) @(posedge mclk);
    high_count(1'b1, h);
    check("pwm b mid", 804, h);
    bus(1'b1, 8'h40, '0);
    repeat (3 * per) @(posedge mclk);
    $display("test pwm done");
  endtask

  // Run about four carrier periods, stop, then judge status and pins
  task automatic run_step(input logic dir, input int n);
    logic [31:0] st;
    logic [3:0] idx;
    logic [1:0] q;
    logic [7:0] lo;
    logic [7:0] hi;
    bus(1'b1, 8'h00, 32'h0000_0015 | {30'h0, dir, 1'b0});
    repeat (4 * per) @(posedge mclk);
    bus(1'b1, 8'h00, 32'h0000_0014 | {30'h0, dir, 1'b0});
    repeat (4) @(posedge mclk);
    bus(1'b0, 8'h0c, '0);
    st = rd;
    idx = st[3:0];
    q = st[5:4];
    lo = duty[idx];
    hi = duty[n - idx];
    check("index", 1'b1, idx < n);
    check("ref a", q[0] ? lo : hi, st[23:16]);
    check("ref b", q[0] ? hi : lo, st[31:24]);
    check("decay", (2 * idx < n) ^ q[0] ^ dir, drv.decay_select);
    check("quadrant", position[1:0], q);
    check("direction", dir, drv.direction_select);
    check("enable", 1'b1, drv.enable);
  endtask

  task automatic t_run();
    bus(1'b1, 8'h04, '0);
    // Coarser resolution first, while the index still rests at zero
    bus(1'b1, 8'h08, 32'h0000_0004);
    bus(1'b0, 8'h08, '0);
    check("steps", 32'h0000_0004, rd);
    run_step(1'b0, 4);
    bus(1'b1, 8'h08, 32'h0000_0008);
    for (int i = 0; i < 8; i++)
      run_step(i >= 4, 8);
    bus(1'b1, 8'h00, 32'h0000_0024);
    repeat (2) @(posedge mclk);
    check("manual decay", 1'b1, drv.decay_select);
    check("driver reset", 1'b0, drv.reset);
    bus(1'b1, 8'h00, 32'h0000_000c);
    repeat (2) @(posedge mclk);
    check("manual decay", 1'b0, drv.decay_select);
    check("driver reset", 1'b1, drv.reset);
    $display("test run done");
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_pwm();
    t_run();
    final_report();
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fails++;
      final_report();
    end
  end
endmodule
